// ===== rtl/rsc_reset_strap_capture.sv
// Summary of operation
// - Upper module strap bits 7..0 show memory data pins 15..8 in order.
// - Upper bits: 7 type, 6-5 speed module three; 4 type, 3-2 speed module four.
// - Module type and speed straps are read-only, driving no controller logic.
// - Upper module strap register loads pins 15..8 at reset.
// - Misc strap bits 4..0 show pins 20..16, bit 5 shows pin 23.
// - Only misc bit 4 is writable; other written bits keep their value.
// - Misc bit 1 selects PCI clock: 0 host clock /2, 1 host clock /3.
// - Misc strap register loads pins 23 and 20..16 at reset.
// - Host synth strap bits 5..0 show pins 26..21.
// - Synth bits 5-3 set synthesizer frequency; bits 2-0 are reserved.
// - Host synth strap register loads its pins at reset.
// - Pin 40 selects core multiplier: low single speed, high double speed.
// - Pins 39..27 and 43..41 are ignored by the device.
//
// The address-and-strobe port was chosen for this implementation.
module rsc_reset_strap_capture
    import rsc_pkg::*;
#(
    parameter int PIN_W = rsc_pkg::RSC_PIN_WIDTH
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // Strap pins
    input  wire logic [PIN_W-1:0] i_memory_data_pins,
    // Register port
    input  wire logic [7:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [7:0]       o_rdata,
    // Strap-controlled outputs
    output logic      [1:0]       o_pci_clk_div,
    output logic      [2:0]       o_host_synth_freq,
    output logic                  o_core_clk_mult
);
    import rsc_pkg::*;

    // ==========================================================
    // Pin synchroniser
    // Runs free through reset so the straps are settled when reset drops
    logic [PIN_W-1:0] pins_s;

    rsc_sync #(
        .WIDTH (PIN_W)
    ) rsc_sync_inst (
        .i_clk   (i_clk),
        .i_async (i_memory_data_pins),
        .o_sync  (pins_s)
    );

    // ==========================================================
    // Capture timing: nothing is sampled while reset is high; one
    // sample is taken just after release, once the synchroniser has flushed
    typedef enum logic [1:0] {
        RSC_IN_RESET,
        RSC_RUN
    } rsc_state_t;

    rsc_state_t state_q;
    rsc_state_t state_d;
    logic       cap_q;
    logic       cap_d;

    always_comb begin
        state_d = state_q;
        cap_d   = 1'b0;
        case (state_q)
            RSC_IN_RESET: begin
                if (!i_reset) begin
                    state_d = RSC_RUN;
                end
            end
            RSC_RUN: begin
                if (i_reset) begin
                    state_d = RSC_IN_RESET;
                end
            end
            default: begin
                state_d = RSC_IN_RESET;
            end
        endcase
        // Release edge: pins have been stable across reset
        if ((state_q == RSC_IN_RESET) && !i_reset) begin
            cap_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        state_q <= state_d;
        cap_q   <= cap_d;
    end

    // ==========================================================
    // Strap registers
    logic [7:0] upper_q;
    logic [7:0] upper_d;
    logic [5:0] misc_q;
    logic [5:0] misc_d;
    logic [5:0] synth_q;
    logic [5:0] synth_d;
    logic       mult_q;
    logic       mult_d;

    // Capture happens once per reset; pins 39..27, 43..41 never read
    always_comb begin
        upper_d = upper_q;
        misc_d  = misc_q;
        synth_d = synth_q;
        mult_d  = mult_q;
        if (cap_q) begin
            upper_d = pins_s[RSC_UPPER_LSB +: 8];
            misc_d  = {pins_s[RSC_MISC_HI_PIN],
                       pins_s[RSC_MISC_LO_LSB +: RSC_MISC_LO_W]};
            synth_d = pins_s[RSC_SYNTH_LSB +: RSC_SYNTH_W];
            mult_d  = pins_s[RSC_CORE_MULT_PIN];
        end else if (i_wr && (i_addr == RSC_ADDR_MISC)) begin
            // Only bit 4 takes the write
            misc_d[RSC_MISC_WR_BIT] = i_wdata[RSC_MISC_WR_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            upper_q <= RSC_ZERO_BYTE;
            misc_q  <= RSC_ZERO_BYTE[5:0];
            synth_q <= RSC_ZERO_BYTE[5:0];
            mult_q  <= RSC_SINGLE_SPEED_MODE;
        end else begin
            upper_q <= upper_d;
            misc_q  <= misc_d;
            synth_q <= synth_d;
            mult_q  <= mult_d;
        end
    end

    // ==========================================================
    // Read port and control outputs
    logic [7:0] rdata_d;
    logic [1:0] pci_d;
    logic [2:0] freq_d;
    logic       mult_o_d;

    // Module type/speed bits only reach the read mux
    always_comb begin
        rdata_d = RSC_ZERO_BYTE;
        if (i_rd) begin
            case (i_addr)
                RSC_ADDR_UPPER_MODULE: rdata_d = upper_q;
                RSC_ADDR_MISC:         rdata_d = {2'h0, misc_q};
                RSC_ADDR_HOST_SYNTH:   rdata_d = {2'h0, synth_q};
                default:               rdata_d = RSC_ZERO_BYTE;
            endcase
        end
        pci_d    = misc_q[RSC_MISC_PCI_BIT] ? RSC_PCI_DIV3 : RSC_PCI_DIV2;
        freq_d   = synth_q[RSC_SYNTH_FREQ_BIT +: RSC_SYNTH_FREQ_W];
        mult_o_d = mult_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata           <= RSC_ZERO_BYTE;
            o_pci_clk_div     <= RSC_PCI_DIV2;
            o_host_synth_freq <= 3'h0;
            o_core_clk_mult   <= RSC_SINGLE_SPEED_MODE;
        end else begin
            o_rdata           <= rdata_d;
            o_pci_clk_div     <= pci_d;
            o_host_synth_freq <= freq_d;
            o_core_clk_mult   <= mult_o_d;
        end
    end

    // ==========================================================
    // Checks: capture pulse
    // Fires only on the edge right after reset drops
    cap_after_release_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |-> !$past(i_reset) && $past(i_reset, 2))
        else $error("capture pulse without reset release");

    // Every release is followed by one capture
    cap_follows_release_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(i_reset) && !i_reset) |=> cap_q)
        else $error("reset release not captured");

    // Straps are taken once, never twice in a row
    cap_single_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |=> !cap_q)
        else $error("capture pulse longer than one cycle");

    // ==========================================================
    // Checks: strap capture
    // Upper module straps land bit for bit
    capture_upper_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |=> upper_q == $past(pins_s[RSC_UPPER_LSB +: 8]))
        else $error("upper strap not captured");

    // Misc straps: low five pins plus the lone high pin
    capture_misc_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |=> misc_q == {$past(pins_s[RSC_MISC_HI_PIN]),
                             $past(pins_s[RSC_MISC_LO_LSB +: RSC_MISC_LO_W])})
        else $error("misc strap not captured");

    // Synthesizer straps land bit for bit
    capture_synth_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |=> synth_q == $past(pins_s[RSC_SYNTH_LSB +: RSC_SYNTH_W]))
        else $error("synth strap not captured");

    // Core multiplier strap is taken with the others
    capture_mult_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |=> mult_q == $past(pins_s[RSC_CORE_MULT_PIN]))
        else $error("core multiplier strap not captured");

    // ==========================================================
    // Checks: hold between resets
    // Bus traffic on the pins after capture must not leak in
    upper_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !cap_q |=> $stable(upper_q))
        else $error("upper strap changed outside capture");

    // Read-only misc bits ignore writes
    misc_ro_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !cap_q |=> $stable(misc_q[RSC_MISC_WR_BIT-1:0]) && $stable(misc_q[RSC_MISC_HI_BIT]))
        else $error("read-only misc bit changed");

    // Writable bit moves only on a write or a capture
    misc_bit4_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !(cap_q || (i_wr && i_addr == RSC_ADDR_MISC)) |=> $stable(misc_q[RSC_MISC_WR_BIT]))
        else $error("misc bit 4 changed without a write");

    // A write outside the capture cycle reaches the writable bit
    misc_wr_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (!cap_q && i_wr && i_addr == RSC_ADDR_MISC)
            |=> misc_q[RSC_MISC_WR_BIT] == $past(i_wdata[RSC_MISC_WR_BIT]))
        else $error("misc bit 4 write lost");

    // Synthesizer straps are read-only
    synth_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !cap_q |=> $stable(synth_q))
        else $error("synth strap changed outside capture");

    // Multiplier strap is read-only
    mult_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !cap_q |=> $stable(mult_q))
        else $error("core multiplier strap changed outside capture");

    // ==========================================================
    // Checks: control outputs
    // Divisor follows misc bit 1 one cycle later
    pci_div_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ##1 o_pci_clk_div == ($past(misc_q[RSC_MISC_PCI_BIT]) ? RSC_PCI_DIV3 : RSC_PCI_DIV2))
        else $error("pci divisor mismatch");

    // Only the two documented divisors may appear
    pci_div_legal_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_pci_clk_div == RSC_PCI_DIV2 || o_pci_clk_div == RSC_PCI_DIV3)
        else $error("pci divisor out of range");

    // Frequency code is the top three synthesizer bits
    synth_freq_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ##1 o_host_synth_freq == $past(synth_q[RSC_SYNTH_FREQ_BIT +: RSC_SYNTH_FREQ_W]))
        else $error("synth frequency mismatch");

    // Multiplier output shows the pin two edges after the capture pulse
    core_mult_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cap_q |=> ##1 o_core_clk_mult == $past(pins_s[RSC_CORE_MULT_PIN], 2))
        else $error("core multiplier mismatch");

    // Multiplier output tracks its register at all times
    mult_track_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ##1 o_core_clk_mult == $past(mult_q))
        else $error("core multiplier output drifted");

    // ==========================================================
    // Checks: read port
    // Upper module strap read
    read_upper_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_rd && i_addr == RSC_ADDR_UPPER_MODULE) |=> o_rdata == $past(upper_q))
        else $error("upper strap read wrong");

    // Misc strap read, top bits zero
    read_misc_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_rd && i_addr == RSC_ADDR_MISC) |=> o_rdata == {2'h0, $past(misc_q)})
        else $error("misc strap read wrong");

    // Synthesizer strap read, top bits zero
    read_synth_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_rd && i_addr == RSC_ADDR_HOST_SYNTH) |=> o_rdata == {2'h0, $past(synth_q)})
        else $error("synth strap read wrong");

    // Read data stand only in the cycle after a read strobe
    read_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_rd |=> o_rdata == RSC_ZERO_BYTE)
        else $error("read data outside a read");

    // Offsets outside this block read as zero
    read_unmapped_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_rd && i_addr != RSC_ADDR_UPPER_MODULE && i_addr != RSC_ADDR_MISC
            && i_addr != RSC_ADDR_HOST_SYNTH) |=> o_rdata == RSC_ZERO_BYTE)
        else $error("unmapped read not zero");

    // ==========================================================
    // Checks: reset values
    // Outputs settle to their idle values while reset is held
    reset_outputs_a: assert property (@(posedge i_clk)
        i_reset |=> o_rdata == RSC_ZERO_BYTE && o_pci_clk_div == RSC_PCI_DIV2
            && o_host_synth_freq == 3'h0
            && o_core_clk_mult == RSC_SINGLE_SPEED_MODE)
        else $error("outputs not cleared by reset");

    // Strap registers are clear until the capture
    reset_regs_a: assert property (@(posedge i_clk)
        i_reset |=> upper_q == '0 && misc_q == '0 && synth_q == '0
            && mult_q == RSC_SINGLE_SPEED_MODE)
        else $error("strap registers not cleared by reset");
endmodule

// ===== rtl/rsc_pkg.sv
package rsc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] RSC_ADDR_UPPER_MODULE = 8'h4b;
    localparam logic [7:0] RSC_ADDR_MISC         = 8'h4c;
    localparam logic [7:0] RSC_ADDR_HOST_SYNTH   = 8'h5f;

    // ==========================================================
    // Strap pin positions on the memory data bus
    localparam int RSC_PIN_WIDTH       = 44;
    localparam int RSC_UPPER_LSB       = 8;
    localparam int RSC_MISC_LO_LSB     = 16;
    localparam int RSC_MISC_HI_PIN     = 23;
    localparam int RSC_SYNTH_LSB       = 21;
    localparam int RSC_SYNTH_FREQ_LSB  = 24;
    localparam int RSC_CORE_MULT_PIN   = 40;

    // ==========================================================
    // Field layout
    localparam int RSC_MISC_LO_W       = 5;
    localparam int RSC_MISC_PCI_BIT    = 1;
    localparam int RSC_MISC_WR_BIT     = 4;
    localparam int RSC_MISC_HI_BIT     = 5;
    localparam int RSC_SYNTH_W         = 6;
    localparam int RSC_SYNTH_FREQ_W    = 3;
    localparam int RSC_SYNTH_FREQ_BIT  = 3;

    // ==========================================================
    // Reset and encoding values
    localparam logic [7:0] RSC_ZERO_BYTE   = 8'h00;
    localparam logic [1:0] RSC_PCI_DIV2    = 2'h2;
    localparam logic [1:0] RSC_PCI_DIV3    = 2'h3;
    localparam logic       RSC_SINGLE_SPEED_MODE = 1'b0;
    localparam logic       RSC_DOUBLE_SPEED_MODE = 1'b1;
endpackage

// ===== rtl/rsc_sync.sv
module rsc_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input  wire logic             i_clk,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // ==========================================================
    // Two-stage synchroniser; first stage feeds only the second
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // No reset on purpose: a cleared stage would hand zeros to the capture at release
    always_ff @(posedge i_clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign o_sync = sync_q;
endmodule

// ===== bench/rsc_board_straps.sv
module rsc_board_straps (
    // Clock
    input  wire logic        i_clk,
    // Board setup
    input  wire logic        i_traffic,
    input  wire logic        i_flip_reserved,
    input  wire logic [43:0] i_user,
    // Memory data pins
    output logic      [43:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Pull resistors on positions that carry no function
    localparam logic [43:0] RSC_RESERVED_MASK = 44'heff_f800_0000;
    localparam logic [43:0] RSC_PULL_UP       = 44'h4f0_0000_0000;
    logic [43:0] strap;
    logic [43:0] traf_q = 44'h000_0000_0000;
    // A misbehaving board may flip the reserved pulls; the device must not care
    assign strap = (i_user & ~RSC_RESERVED_MASK)
                 | ((RSC_PULL_UP ^ (i_flip_reserved ? RSC_RESERVED_MASK : 44'h0))
                 & RSC_RESERVED_MASK);
    // After reset the bus carries memory traffic, so pins change every cycle
    always @(posedge i_clk) begin
        traf_q <= {traf_q[42:0], ~traf_q[43]};
    end
    assign o_pins = i_traffic ? (~strap ^ traf_q) : strap;
endmodule

// ===== bench/reset_strap_capture_bench.sv
module reset_strap_capture_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rsc_pkg::*;
    // ==========================================================
    // Stimulus and wiring
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        traffic = 1'b0;
    logic        flip = 1'b0;
    logic [43:0] user = 44'h000_0000_0000;
    logic [43:0] pins;
    logic [7:0]  o_rdata;
    logic [1:0]  o_pci_clk_div;
    logic [2:0]  o_host_synth_freq;
    logic        o_core_clk_mult;
    logic [43:0] pat;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;
    rsc_board_straps rsc_board_straps_inst (.i_clk(i_clk), .i_traffic(traffic),
        .i_flip_reserved(flip), .i_user(user), .o_pins(pins));
    rsc_reset_strap_capture rsc_reset_strap_capture_inst (.i_clk(i_clk), .i_reset(i_reset),
        .i_memory_data_pins(pins), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_pci_clk_div(o_pci_clk_div),
        .o_host_synth_freq(o_host_synth_freq), .o_core_clk_mult(o_core_clk_mult));
    // ==========================================================
    // Clock and hang guard; the whole run needs well under 300 cycles
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    // ==========================================================
    // Bus tasks, entered right after a rising edge
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // Read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, exp);
        @(posedge i_clk);
    endtask
    // Reset with straps stable, then let the bus run traffic over the pins
    task automatic do_reset(input logic [43:0] p);
        user <= p;
        traffic <= 1'b0;
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_clk);
        traffic <= 1'b1;
        @(posedge i_clk);
    endtask
    task automatic check_all(input logic [43:0] p, input logic b4);
        rd(RSC_ADDR_UPPER_MODULE, p[15:8]);
        rd(RSC_ADDR_MISC, {2'h0, p[23], b4, p[19:16]});
        rd(RSC_ADDR_HOST_SYNTH, {2'h0, p[26:21]});
        // Control outputs are read mid-cycle, away from the edge that updates them
        @(negedge i_clk);
        check({6'h00, o_pci_clk_div}, p[17] ? 8'h03 : 8'h02);
        check({5'h00, o_host_synth_freq}, {5'h00, p[26:24]});
        check({7'h00, o_core_clk_mult}, {7'h00, p[40]});
        @(posedge i_clk);
    endtask
    task automatic stop_test();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================================
    // Two complementary strap sets; the second with the reserved pulls flipped
    initial begin
        for (int k = 0; k < 2; k++) begin
            pat = (k == 0) ? 44'h5a5_a5a5_a5a5 : 44'ha5a_5a5a_5a5a;
            flip <= k[0];
            do_reset(pat);
            check_all(pat, pat[20]);
            rd(8'h4a, 8'h00);
            wr(RSC_ADDR_UPPER_MODULE, ~pat[15:8]);
            wr(RSC_ADDR_HOST_SYNTH, 8'hff);
            wr(RSC_ADDR_MISC, {2'h3, ~pat[23], ~pat[20:16]});
            check_all(pat, ~pat[20]);
            wr(RSC_ADDR_MISC, {2'h0, pat[23], pat[20:16]});
            rd(RSC_ADDR_MISC, {2'h0, pat[23], pat[20:16]});
        end
        stop_test();
    end
endmodule
